// ===== core/strap_link_pins.sv
// strap capture, link indicator drive, rom and management pin logic
`timescale 1ns/1ps
module strap_link_pins #(
    parameter int unsigned BLINK_PHASE = pin_pkg::BLINK_PHASE_CYC
) (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              system_reset_n,
    input  wire logic [7:0]                        link_up,
    input  wire logic [7:0]                        link_fast,
    input  wire logic [7:0]                        link_indicator_in,
    output logic      [7:0]                        link_indicator_out,
    output logic      [7:0]                        link_indicator_oe,
    input  wire logic [4:0]                        gpio_sel_in,
    input  wire logic [3:0]                        upstream_port_choice_in,
    output logic      [3:0]                        upstream_port_choice,
    output logic                                   debug_mode,
    output logic                                   init_done,
    input  wire logic [2:0]                        i2c_addr_in,
    input  wire logic                              smbus_en_n_in,
    output logic      [6:0]                        slave_addr,
    output logic                                   i2c_mode,
    input  wire logic                              mgmt_sda_in,
    input  wire logic                              sda_pull_low,
    output logic                                   sda_level,
    output logic                                   mgmt_sda_out,
    output logic                                   mgmt_sda_oe,
    input  wire logic                              rom_start,
    input  wire logic [pin_pkg::ROM_WORD_W-1:0]    rom_tx_word,
    input  wire logic [pin_pkg::ROM_CNT_W-1:0]     rom_nbits,
    output logic      [pin_pkg::ROM_WORD_W-1:0]    rom_rx_word,
    output logic                                   rom_busy,
    output logic                                   rom_done,
    output logic                                   rom_enabled,
    output logic                                   rom_clock,
    output logic                                   rom_serial_in,
    input  wire logic                              rom_serial_out,
    input  wire logic                              rom_select_n_in,
    output logic                                   rom_select_n,
    output logic                                   rom_select_oe
);
    import pin_pkg::*;

    // two-stage synchronisers for every pin input
    logic       rstn_m_q,  rstn_s_q;
    logic       dbg_m_q,   dbg_s_q;
    logic       ind_m_q,   ind_s_q;
    logic       lamp_m_q,  lamp_s_q;
    logic       byp_m_q,   byp_s_q;
    logic       smb_m_q,   smb_s_q;
    logic       sda_m_q;
    logic       rdo_m_q,   rdo_s_q;
    logic [3:0] ups_m_q,   ups_s_q;
    logic [2:0] addr_m_q,  addr_s_q;
    logic [4:0] gsel_m_q,  gsel_s_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            rstn_m_q <= 1'b0;
            rstn_s_q <= 1'b0;
        end else begin
            rstn_m_q <= system_reset_n;
            rstn_s_q <= rstn_m_q;
        end
    end

    always_ff @(posedge clk) begin
        dbg_m_q   <= link_indicator_in[DEBUG_PIN];
        dbg_s_q   <= dbg_m_q;
        ind_m_q   <= link_indicator_in[IND_OFF_PIN];
        ind_s_q   <= ind_m_q;
        lamp_m_q  <= link_indicator_in[LAMP_PIN];
        lamp_s_q  <= lamp_m_q;
        byp_m_q   <= rom_select_n_in;
        byp_s_q   <= byp_m_q;
        smb_m_q   <= smbus_en_n_in;
        smb_s_q   <= smb_m_q;
        sda_m_q   <= mgmt_sda_in;
        sda_level <= sda_m_q;
        rdo_m_q   <= rom_serial_out;
        rdo_s_q   <= rdo_m_q;
        ups_m_q   <= upstream_port_choice_in;
        ups_s_q   <= ups_m_q;
        addr_m_q  <= i2c_addr_in;
        addr_s_q  <= addr_m_q;
        gsel_m_q  <= gpio_sel_in;
        gsel_s_q  <= gsel_m_q;
    end

    // either the core reset or the pin reset holds the block
    logic int_rst;
    assign int_rst = rst || !rstn_s_q; // R17

    // strap latches, captured once on the first cycle after release
    logic in_init_q;
    logic debug_off_q;
    logic ind_off_q;
    logic lamp_debug_q;
    logic rom_bypass_n_q;

    always_ff @(posedge clk) begin // R18
        if (int_rst) begin
            in_init_q            <= 1'b1;
            debug_off_q          <= DEBUG_OFF_RST;
            ind_off_q            <= IND_OFF_RST;
            lamp_debug_q         <= LAMP_DEBUG_RST;
            rom_bypass_n_q       <= ROM_BYPASS_RST;
            i2c_mode             <= SMBUS_EN_RST;
            upstream_port_choice <= UPSTREAM_RST;
            slave_addr           <= {SLAVE_ADDR_HI, ADDR_LOW_RST};
        end else if (in_init_q) begin
            in_init_q            <= 1'b0;
            debug_off_q          <= dbg_s_q;  // R6
            ind_off_q            <= ind_s_q;  // R7
            lamp_debug_q         <= lamp_s_q; // R8
            rom_bypass_n_q       <= byp_s_q;  // R12
            i2c_mode             <= smb_s_q;  // R15
            upstream_port_choice <= ups_s_q;  // R9
            slave_addr           <= {SLAVE_ADDR_HI, addr_s_q}; // R13
        end
    end

    always_ff @(posedge clk) begin
        if (int_rst) begin
            init_done   <= 1'b0;
            debug_mode  <= 1'b0;
            rom_enabled <= 1'b0;
        end else begin
            init_done   <= !in_init_q;
            debug_mode  <= !in_init_q && !debug_off_q; // R6
            rom_enabled <= !in_init_q && rom_bypass_n_q;
        end
    end

    // indicators carry status only with both straps low and code 01011
    logic ind_en;
    assign ind_en = !in_init_q && !ind_off_q && !lamp_debug_q
                    && gsel_s_q == LAMP_SEL_CODE; // R4 R16

    logic blink;

    blink_timer #(
        .PHASE_CYC (BLINK_PHASE)
    ) u_blink (
        .clk   (clk),
        .rst   (int_rst),
        .blink (blink)
    );

    // pins float during init so the straps can be read
    always_ff @(posedge clk) begin
        if (int_rst) begin
            link_indicator_oe  <= 8'h00;
            link_indicator_out <= 8'h00;
        end else begin
            link_indicator_oe <= in_init_q ? 8'h00 : LANE_MASK; // R5
            for (int x = 0; x < 8; x++) begin
                if (!LANE_MASK[x] || !ind_en) begin
                    link_indicator_out[x] <= 1'b0; // R4
                end else if (!link_up[x]) begin
                    link_indicator_out[x] <= 1'b1; // R1
                end else if (link_fast[x]) begin
                    link_indicator_out[x] <= 1'b0; // R2
                end else begin
                    link_indicator_out[x] <= blink; // R3
                end
            end
        end
    end

    // open-drain data line: output level is always low
    always_ff @(posedge clk) begin // R14
        if (int_rst) begin
            mgmt_sda_out <= 1'b0;
            mgmt_sda_oe  <= 1'b0;
        end else begin
            mgmt_sda_out <= 1'b0;
            mgmt_sda_oe  <= sda_pull_low;
        end
    end

    // select pin is a strap until init ends, then always driven
    always_ff @(posedge clk) begin
        if (int_rst) begin
            rom_select_oe <= 1'b0;
        end else begin
            rom_select_oe <= !in_init_q;
        end
    end

    rom_shifter u_rom (
        .clk           (clk),
        .rst           (int_rst),
        .enable        (rom_enabled),
        .start         (rom_start),
        .tx_word       (rom_tx_word),
        .nbits         (rom_nbits),
        .data_from_rom (rdo_s_q),
        .rx_word       (rom_rx_word),
        .busy          (rom_busy),
        .done          (rom_done),
        .rom_clock     (rom_clock),
        .rom_serial_in (rom_serial_in),
        .rom_select_n  (rom_select_n)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence lane_live(int x, logic cond);
        !int_rst && ind_en && LANE_MASK[x] && cond;
    endsequence

    chk_down_solid_on: assert property ( // R1
        lane_live(0, !link_up[0]) |=> link_indicator_out[0])
        else $error("link down lane not solid on");
    chk_fast_held_off: assert property ( // R2
        lane_live(1, link_up[1] && link_fast[1]) |=> !link_indicator_out[1])
        else $error("fast lane indicator not off");
    chk_slow_follows_blink: assert property ( // R3
        lane_live(4, link_up[4] && !link_fast[4])
        |=> link_indicator_out[4] == $past(blink))
        else $error("slow lane not blinking");
    chk_gated_dark: assert property ( // R4
        !int_rst && (ind_off_q || gsel_s_q != LAMP_SEL_CODE)
        |=> link_indicator_out == 8'h00)
        else $error("indicator driven while gated");
    chk_unused_lanes_idle: assert property ( // R5
        link_indicator_oe[3:2] == 2'h0 && link_indicator_out[3:2] == 2'h0)
        else $error("lanes two or three driven");
    chk_strap_debug_latch: assert property ( // R6
        $fell(in_init_q) |-> debug_off_q == $past(dbg_s_q) ##1 debug_mode == !debug_off_q)
        else $error("debug strap not latched");
    chk_straps_frozen: assert property ( // R18
        !int_rst && !in_init_q && !$past(in_init_q)
        |-> $stable(ind_off_q) && $stable(lamp_debug_q) && $stable(slave_addr)
            && $stable(upstream_port_choice) && $stable(rom_bypass_n_q))
        else $error("strap changed after capture");
    chk_addr_low_bits: assert property ( // R13
        $fell(in_init_q) |-> slave_addr == {SLAVE_ADDR_HI, $past(addr_s_q)})
        else $error("slave address low bits wrong");
    chk_sda_low_only: assert property ( // R14
        mgmt_sda_oe |-> !mgmt_sda_out)
        else $error("management data driven high");
    chk_sda_release: assert property ( // R14
        !int_rst && !sda_pull_low |=> !mgmt_sda_oe)
        else $error("management data not released");
    chk_pins_float_init: assert property ( // R17
        int_rst |=> link_indicator_oe == 8'h00 && !rom_select_oe && in_init_q)
        else $error("pins driven during reset");
endmodule

// ===== common/pin_pkg.sv
// constants for the strap, link indicator and serial rom pin logic
// Operation
// [R1] link down: indicator held asserted
// [R2] link up at 5 GT/s: indicator held off
// [R3] link up at 2.5 GT/s: blink, 0.2 s phases
// [R4] indicators live only when strap low, select 01011
// [R5] indicator x reports lane x, x=0,1,4..7
// [R6] indicator pin 1 at init: debug-off strap
// [R7] indicator pin 5 at init: indicator-off strap
// [R8] indicator pin 6 at init: lamp debug strap
// [R9] four-bit upstream port choice, default zero
// [R10] drive rom clock, shift out, sample in
// [R11] rom select low enables rom access
// [R12] rom select pin at init: bypass strap
// [R13] slave address low three bits from pins
// [R14] management data line driven low only
// [R15] protocol strap high i2c, low smbus
// [R16] debug mode uses gpio[4:0] as selection
// [R17] system reset initialises all state; the two-stage pin synchronisers have no reset, except the system_reset_n one, which rst clears
// [R18] straps latched once at reset release
// [R19] one shared blink counter for lanes
package pin_pkg;
    localparam int          CLK_KHZ         = 50_000;
    localparam int          CLK_NS          = 20;
    localparam int          BLINK_PHASE_MS  = 200;
    localparam int          BLINK_PHASE_CYC = BLINK_PHASE_MS * CLK_KHZ;
    localparam int          BLINK_CNT_W     = 24;
    localparam int          ROM_HALF_NS     = 500;
    localparam int          ROM_HALF_CYC    = (ROM_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int          ROM_DIV_W       = 6;
    localparam int          ROM_WORD_W      = 32;
    localparam int          ROM_CNT_W       = 6;
    localparam logic [7:0]  LANE_MASK       = 8'hf3;
    localparam int          DEBUG_PIN       = 1;
    localparam int          IND_OFF_PIN     = 5;
    localparam int          LAMP_PIN        = 6;
    localparam logic [4:0]  LAMP_SEL_CODE   = 5'h0b;
    localparam logic [3:0]  SLAVE_ADDR_HI   = 4'h0;
    localparam logic        DEBUG_OFF_RST   = 1'h1;
    localparam logic        IND_OFF_RST     = 1'h1;
    localparam logic        LAMP_DEBUG_RST  = 1'h1;
    localparam logic        ROM_BYPASS_RST  = 1'h1;
    localparam logic        SMBUS_EN_RST    = 1'h1;
    localparam logic [3:0]  UPSTREAM_RST    = 4'h0;
    localparam logic [2:0]  ADDR_LOW_RST    = 3'h0;

    typedef enum logic [1:0] {ROM_IDLE, ROM_LOW, ROM_HIGH, ROM_TAIL} rom_state_e;
endpackage

// ===== core/blink_timer.sv
// shared blink phase generator for all link indicators
`timescale 1ns/1ps
module blink_timer #(
    parameter int unsigned PHASE_CYC = pin_pkg::BLINK_PHASE_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      blink
);
    import pin_pkg::*;

    logic [BLINK_CNT_W-1:0] cnt_q;
    localparam logic [BLINK_CNT_W-1:0] LAST = BLINK_CNT_W'(PHASE_CYC - 1);

    // one counter for every lane keeps all blinking lanes in phase
    always_ff @(posedge clk) begin // R19
        if (rst) begin
            cnt_q <= '0;
            blink <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
            blink <= ~blink; // R3
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    logic [BLINK_CNT_W-1:0] held_q;
    // counts edges since the last toggle, reset counts as a toggle one edge early
    always_ff @(posedge clk) begin
        if (rst) begin
            held_q <= '0;
        end else if (blink != $past(blink)) begin
            held_q <= BLINK_CNT_W'(1);
        end else begin
            held_q <= held_q + 1'b1;
        end
    end

    chk_blink_phase_len: assert property (@(posedge clk) disable iff (rst) // R3
        (blink != $past(blink)) && !$past(rst, 2) |-> held_q == BLINK_CNT_W'(PHASE_CYC))
        else $error("blink phase length wrong");
endmodule

// ===== core/rom_shifter.sv
// 4-wire serial rom master shift engine
`timescale 1ns/1ps
module rom_shifter (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              enable,
    input  wire logic                              start,
    input  wire logic [pin_pkg::ROM_WORD_W-1:0]    tx_word,
    input  wire logic [pin_pkg::ROM_CNT_W-1:0]     nbits,
    input  wire logic                              data_from_rom,
    output logic      [pin_pkg::ROM_WORD_W-1:0]    rx_word,
    output logic                                   busy,
    output logic                                   done,
    output logic                                   rom_clock,
    output logic                                   rom_serial_in,
    output logic                                   rom_select_n
);
    import pin_pkg::*;

    localparam logic [ROM_DIV_W-1:0] DIV_LAST = ROM_DIV_W'(ROM_HALF_CYC - 1);

    rom_state_e                state_q;
    logic [ROM_DIV_W-1:0]      div_q;
    logic [ROM_CNT_W-1:0]      left_q;
    logic [ROM_WORD_W-1:0]     tx_q;
    logic                      tick;

    assign tick = (div_q == DIV_LAST);

    always_ff @(posedge clk) begin
        if (rst || state_q == ROM_IDLE || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // data changes while clock is low, rom samples on rising edge
    always_ff @(posedge clk) begin // R10
        if (rst) begin
            state_q       <= ROM_IDLE;
            left_q        <= '0;
            tx_q          <= '0;
            rx_word       <= '0;
            busy          <= 1'b0;
            done          <= 1'b0;
            rom_clock     <= 1'b0;
            rom_serial_in <= 1'b0;
            rom_select_n  <= 1'b1;
        end else begin
            done <= 1'b0;
            unique case (state_q)
                ROM_IDLE: begin
                    // bypass strap low refuses every access
                    if (start && enable && nbits != '0) begin // R12
                        state_q       <= ROM_LOW;
                        busy          <= 1'b1;
                        rom_select_n  <= 1'b0; // R11
                        left_q        <= nbits;
                        tx_q          <= tx_word << 1;
                        rom_serial_in <= tx_word[ROM_WORD_W-1];
                    end
                end
                ROM_LOW: begin
                    if (tick) begin
                        state_q   <= ROM_HIGH;
                        rom_clock <= 1'b1;
                    end
                end
                ROM_HIGH: begin
                    // late sample covers the two-stage input synchroniser
                    if (tick) begin
                        rom_clock <= 1'b0;
                        rx_word   <= {rx_word[ROM_WORD_W-2:0], data_from_rom};
                        left_q    <= left_q - 1'b1;
                        if (left_q == ROM_CNT_W'(1)) begin
                            state_q <= ROM_TAIL;
                        end else begin
                            state_q       <= ROM_LOW;
                            rom_serial_in <= tx_q[ROM_WORD_W-1];
                            tx_q          <= tx_q << 1;
                        end
                    end
                end
                ROM_TAIL: begin
                    if (tick) begin
                        state_q      <= ROM_IDLE;
                        rom_select_n <= 1'b1;
                        busy         <= 1'b0;
                        done         <= 1'b1;
                    end
                end
            endcase
        end
    end

    sequence start_ok;
        start && enable && nbits != '0 && state_q == ROM_IDLE;
    endsequence

    chk_rom_start_select: assert property (@(posedge clk) disable iff (rst) // R11
        start_ok |=> busy && !rom_select_n ##1 !rom_clock)
        else $error("rom access did not select the rom");
    chk_rom_bypass_refuse: assert property (@(posedge clk) disable iff (rst) // R12
        !enable && state_q == ROM_IDLE |=> !busy && rom_select_n)
        else $error("rom access while bypassed");
    chk_rom_clock_selected: assert property (@(posedge clk) disable iff (rst) // R10
        $rose(rom_clock) |-> !rom_select_n && $stable(rom_serial_in))
        else $error("rom clock edge outside select or data moving");
endmodule

// ===== dv/rom_model.sv
// behavioural serial rom answering the 4-wire master
`timescale 1ns/1ps
module rom_model (
    input  wire logic        rom_clock,
    input  wire logic        rom_serial_in,
    input  wire logic        rom_select_n,
    input  wire logic [31:0] reply,
    output logic             rom_serial_out,
    output logic [31:0]      got_word
);
    int idx = 0;
    initial rom_serial_out = 1'b0;
    initial got_word = 32'h0;
    // deselect: line no longer holds the last bit; select: restart;
    // clock rise: capture the master's bit and launch the next reply bit, msb first
    always @(posedge rom_clock or negedge rom_select_n or posedge rom_select_n) begin
        if (rom_select_n === 1'b1) begin
            rom_serial_out = ~rom_serial_out;
        end else if (rom_clock !== 1'b1) begin
            idx = 0;
            got_word = 32'h0;
        end else begin
            got_word = {got_word[30:0], rom_serial_in};
            rom_serial_out = reply[31 - (idx % 32)];
            idx++;
        end
    end
endmodule

// ===== dv/strap_link_pins_bench.sv
// self-checking bench for the strap, link indicator, rom and management pins
`timescale 1ns/1ps
module strap_link_pins_bench;
    import pin_pkg::*;
    localparam int PH = 8;
    logic        clk = 0, rst = 1, sys_n = 0, pull = 0, smb_n = 1, start = 0, rs_strap = 1;
    logic [7:0]  link_up = 0, link_fast = 0, strap = 8'hff, ind_out, ind_oe, ind_in;
    logic [4:0]  gpio = 0;
    logic [3:0]  ups_in = 0, ups;
    logic [2:0]  addr_in = 0;
    logic [6:0]  saddr;
    logic        dbg, init_done, i2c_mode, sda_level, sda_out, sda_oe, sda_in, t;
    logic        busy, done, rom_en, rck, rsi, rso, rsel, rsel_oe, rsel_in;
    logic [31:0] tx = 0, rx, reply = 0, got, m, e;
    logic [5:0]  nb = 1;
    logic [31:0] exp_q[$], mask_q[$];
    int          errors = 0, checks_done = 0, cycles = 0, i, k;

    // pins: straps are seen while the device is not driving
    assign ind_in  = (ind_oe & ind_out) | (~ind_oe & strap);
    assign rsel_in = rsel_oe ? rsel : rs_strap;
    assign sda_in  = ~(sda_oe & ~sda_out);

    strap_link_pins #(.BLINK_PHASE(PH)) u_strap_link_pins (
        .clk(clk), .rst(rst), .system_reset_n(sys_n), .link_up(link_up),
        .link_fast(link_fast), .link_indicator_in(ind_in), .link_indicator_out(ind_out),
        .link_indicator_oe(ind_oe), .gpio_sel_in(gpio), .upstream_port_choice_in(ups_in),
        .upstream_port_choice(ups), .debug_mode(dbg), .init_done(init_done),
        .i2c_addr_in(addr_in), .smbus_en_n_in(smb_n), .slave_addr(saddr),
        .i2c_mode(i2c_mode), .mgmt_sda_in(sda_in), .sda_pull_low(pull),
        .sda_level(sda_level), .mgmt_sda_out(sda_out), .mgmt_sda_oe(sda_oe),
        .rom_start(start), .rom_tx_word(tx), .rom_nbits(nb), .rom_rx_word(rx),
        .rom_busy(busy), .rom_done(done), .rom_enabled(rom_en), .rom_clock(rck),
        .rom_serial_in(rsi), .rom_serial_out(rso), .rom_select_n_in(rsel_in),
        .rom_select_n(rsel), .rom_select_oe(rsel_oe)
    );
    rom_model u_rom_model (
        .rom_clock(rck), .rom_serial_in(rsi), .rom_select_n(rsel),
        .reply(reply), .rom_serial_out(rso), .got_word(got)
    );

    always #10 clk = ~clk;

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end

    // result watcher: each done pulse takes the oldest noted rom word
    always @(negedge clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("rom_done_unexpected", 32'h1, 32'h0);
            end else begin
                m = mask_q.pop_front();
                e = exp_q.pop_front();
                check("rom_rx_word", rx & m, e);
            end
        end
    end

    task automatic do_reset(logic [7:0] s, logic r, logic rs);
        logic [3:0] u;
        logic [2:0] a;
        logic       b;
        @(negedge clk);
        strap = s;
        rs_strap = rs;
        rst = r;
        sys_n = 0;
        u = $urandom;
        a = $urandom;
        b = $urandom;
        ups_in = u;
        addr_in = a;
        smb_n = b;
        repeat (16) @(negedge clk);
        check("oe_in_reset", ind_oe, 8'h00);
        check("rom_select_n_reset", rsel, 32'h1);
        check("rsel_oe_reset", rsel_oe, 32'h0);
        rst = 0;
        sys_n = 1;
        k = 0;
        while (init_done !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        check("init_done", init_done, 32'h1);
        check("upstream", ups, u);
        check("slave_addr", saddr, {SLAVE_ADDR_HI, a});
        check("i2c_mode", i2c_mode, b);
        check("debug_mode", dbg, !s[DEBUG_PIN]);
        check("rom_enabled", rom_en, rs);
        check("rsel_oe_after_init", rsel_oe, 32'h1);
        check("oe_after_init", ind_oe, LANE_MASK);
        ups_in = ~u;
        addr_in = ~a;
        smb_n = ~b;
        strap = ~s;
        repeat (4) @(negedge clk);
        check("upstream_held", ups, u);
        check("addr_held", saddr, {SLAVE_ADDR_HI, a});
        check("i2c_held", i2c_mode, b);
        check("debug_held", dbg, !s[DEBUG_PIN]);
    endtask

    task automatic ind_chk(logic [7:0] up, logic [7:0] fast, logic [7:0] exp);
        link_up = up;
        link_fast = fast;
        repeat (2) @(negedge clk);
        check("link_indicator", ind_out, exp);
    endtask

    task automatic rom_xfer(int n);
        @(negedge clk);
        reply = $urandom;
        tx = $urandom;
        nb = n;
        start = 1;
        exp_q.push_back(reply >> (32 - n));
        m = (n == 32) ? 32'hffffffff : ((32'h1 << n) - 32'h1);
        mask_q.push_back(m);
        @(negedge clk);
        start = 0;
        check("rom_select_n_active", rsel, 32'h0);
        check("rom_busy", busy, 32'h1);
        k = 0;
        while (done !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        check("rom_done_seen", done, 32'h1);
        check("rom_seen_tx", got & m, tx >> (32 - n));
    endtask

    initial begin
        void'($urandom(4746));
        do_reset(8'h9d, 1'b1, 1'b1);
        gpio = LAMP_SEL_CODE;
        repeat (4) @(negedge clk);
        ind_chk(8'h00, 8'h00, LANE_MASK);
        ind_chk(8'hff, 8'hff, 8'h00);
        for (i = 0; i < 6; i++) begin
            e = $urandom;
            ind_chk(e[7:0], 8'hff, ~e[7:0] & LANE_MASK);
        end
        link_up = 8'hff;
        link_fast = 8'h00;
        for (i = 0; i < 3; i++) begin
            t = ind_out[0];
            k = 0;
            while (ind_out[0] === t && k < 40) begin
                @(negedge clk);
                k++;
            end
        end
        check("blink_phase", k, PH);
        check("blink_lanes", ind_out, {8{~t}} & LANE_MASK);
        link_up = 8'h00;
        for (i = 0; i < 5; i++) begin
            gpio = LAMP_SEL_CODE ^ (5'h01 << i);
            repeat (4) @(negedge clk);
            check("gpio_gate", ind_out, 8'h00);
        end
        gpio = LAMP_SEL_CODE;
        pull = 1;
        @(negedge clk);
        check("sda_oe", sda_oe, 32'h1);
        check("sda_out", sda_out, 32'h0);
        repeat (3) @(negedge clk);
        check("sda_low", sda_level, 32'h0);
        pull = 0;
        repeat (4) @(negedge clk);
        check("sda_released", sda_level, 32'h1);
        rom_xfer(1);
        rom_xfer(32);
        rom_xfer(($urandom % 32) + 1);
        do_reset(8'hbf, 1'b0, 1'b0);
        check("ind_off_strap", ind_out, 8'h00);
        start = 1;
        repeat (3) @(negedge clk);
        start = 0;
        check("rom_bypassed", busy, 32'h0);
        check("rom_bypass_sel", rsel, 32'h1);
        do_reset(8'hdd, 1'b1, 1'b1);
        check("lamp_strap", ind_out, 8'h00);
        summarize();
    end
endmodule
